/* File: include/sgcf_defs.vh */
// Constants for the serial gated clock fan-out block.
// Assumes inclusion by bare name from the core files; definitions only.
`ifndef SGCF_DEFS_VH
`define SGCF_DEFS_VH
`define SGCF_NUM_OUT        10
`define SGCF_TARGET_ADDR    7'h69
`define SGCF_NUM_CFG_BYTES  2'h3
`define SGCF_GATE_RESET     8'hFF
`define SGCF_LOW_LSB        0
`define SGCF_MID_LSB        4
`define SGCF_HIGH_LSB       6
`define SGCF_ST_IDLE        3'h0
`define SGCF_ST_ADDR        3'h1
`define SGCF_ST_ACK         3'h2
`define SGCF_ST_CMD         3'h3
`define SGCF_ST_CNT         3'h4
`define SGCF_ST_DATA        3'h5
`define SGCF_ST_IGNORE      3'h6
`endif

/* File: core/sgcf_out_gate.v */
// Per-output gate: glitch-free enable capture and three-state control.
// Assumes refClk is already synchronised to sys_clk.
`timescale 1ns/1ns
`include "sgcf_defs.vh"
module sgcf_out_gate (
  input  wire                    sys_clk,
  input  wire                    srst,
  input  wire                    refClk,
  input  wire                    outEnable,
  input  wire [`SGCF_NUM_OUT-1:0] gateReq,
  output reg  [`SGCF_NUM_OUT-1:0] clkOut_ff,
  output reg  [`SGCF_NUM_OUT-1:0] clkOe_ff
);
  reg [`SGCF_NUM_OUT-1:0] gateLive_ff;

  always @(posedge sys_clk) begin
    if (srst) begin
      gateLive_ff <= {`SGCF_NUM_OUT{1'b1}};
      clkOut_ff   <= {`SGCF_NUM_OUT{1'b0}};
      clkOe_ff    <= {`SGCF_NUM_OUT{1'b0}};
    end else begin
      // Only load new enables while the reference is low: no runt pulses
      if (!refClk) begin
        gateLive_ff <= gateReq;
      end
      clkOut_ff <= {`SGCF_NUM_OUT{refClk}} & gateLive_ff;
      clkOe_ff  <= {`SGCF_NUM_OUT{outEnable}};
    end
  end
endmodule // sgcf_out_gate

/* File: core/sgcf_fanout.v */
// Top of the serial gated clock fan-out: serial receiver, gate bytes, outputs.
// Assumes all pins are asynchronous to sys_clk; the serial clock is much slower.
`timescale 1ns/1ns
`include "sgcf_defs.vh"
module sgcf_fanout (
  input  wire                     sys_clk,
  input  wire                     srst,
  input  wire                     refClkPin,
  input  wire                     outEnablePin,
  input  wire                     serialClkPin,
  input  wire                     serialDataIn,
  output reg                      serialDataOut_ff,
  output reg                      serialDataOe_ff,
  output wire [`SGCF_NUM_OUT-1:0] fanoutClk,
  output wire [`SGCF_NUM_OUT-1:0] fanoutOe
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] refSync_ff;
  reg [1:0] oeSync_ff;
  reg [1:0] sclSync_ff;
  reg [1:0] sdaSync_ff;
  reg       sclPrev_ff;
  reg       sdaPrev_ff;

  always @(posedge sys_clk) begin
    if (srst) begin
      refSync_ff <= 2'h0;
      oeSync_ff  <= 2'h3;
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      refSync_ff <= {refSync_ff[0], refClkPin};
      oeSync_ff  <= {oeSync_ff[0], outEnablePin};
      sclSync_ff <= {sclSync_ff[0], serialClkPin};
      sdaSync_ff <= {sdaSync_ff[0], serialDataIn};
      sclPrev_ff <= sclSync_ff[1];
      sdaPrev_ff <= sdaSync_ff[1];
    end
  end

  wire scl      = sclSync_ff[1];
  wire sda      = sdaSync_ff[1];
  wire sclRise  = scl & ~sclPrev_ff;
  wire sclFall  = ~scl & sclPrev_ff;
  wire startSeen = scl & sclPrev_ff & sdaPrev_ff & ~sda;
  wire stopSeen  = scl & sclPrev_ff & ~sdaPrev_ff & sda;

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver: address, command code, byte count, then data bytes
  reg [2:0] state_ff;
  reg [2:0] retState_ff;
  reg [2:0] bitCnt_ff;
  reg [7:0] shift_ff;
  reg [1:0] byteIdx_ff;
  reg       ackPending_ff;
  reg [7:0] gateLow_ff;
  reg [7:0] gateMid_ff;
  reg [7:0] gateHigh_ff;

  // Block-write framing: command and count bytes are acked and discarded
  always @(posedge sys_clk) begin
    if (srst) begin
      state_ff         <= `SGCF_ST_IDLE;
      retState_ff      <= `SGCF_ST_IDLE;
      bitCnt_ff        <= 3'h0;
      shift_ff         <= 8'h00;
      byteIdx_ff       <= 2'h0;
      ackPending_ff    <= 1'b0;
      serialDataOut_ff <= 1'b0;
      serialDataOe_ff  <= 1'b0;
      gateLow_ff       <= `SGCF_GATE_RESET;
      gateMid_ff       <= `SGCF_GATE_RESET;
      gateHigh_ff      <= `SGCF_GATE_RESET;
    end else if (startSeen) begin
      state_ff        <= `SGCF_ST_ADDR;
      bitCnt_ff       <= 3'h0;
      byteIdx_ff      <= 2'h0;
      serialDataOe_ff <= 1'b0;
    end else if (stopSeen) begin
      state_ff        <= `SGCF_ST_IDLE;
      serialDataOe_ff <= 1'b0;
    end else begin
      case (state_ff)
        `SGCF_ST_ADDR, `SGCF_ST_CMD, `SGCF_ST_CNT, `SGCF_ST_DATA: begin
          if (sclRise) begin
            shift_ff  <= {shift_ff[6:0], sda};
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (bitCnt_ff == 3'h7) begin
              ackPending_ff <= 1'b1;
            end
          end
          if (sclFall && ackPending_ff) begin
            ackPending_ff <= 1'b0;
            if (state_ff == `SGCF_ST_ADDR) begin
              // Address A6 first, direction last; reads are not supported
              if (shift_ff[7:1] == `SGCF_TARGET_ADDR && !shift_ff[0]) begin
                serialDataOe_ff <= 1'b1;
                retState_ff     <= `SGCF_ST_CMD;
                state_ff        <= `SGCF_ST_ACK;
              end else begin
                state_ff <= `SGCF_ST_IGNORE;
              end
            end else begin
              serialDataOe_ff <= 1'b1;
              state_ff        <= `SGCF_ST_ACK;
              if (state_ff == `SGCF_ST_CMD) begin
                retState_ff <= `SGCF_ST_CNT;
              end else begin
                retState_ff <= `SGCF_ST_DATA;
              end
              if (state_ff == `SGCF_ST_DATA) begin
                // Unused bits are stored but never used
                case (byteIdx_ff)
                  2'h0: gateLow_ff  <= shift_ff;
                  2'h1: gateMid_ff  <= shift_ff;
                  2'h2: gateHigh_ff <= shift_ff;
                  default: ;
                endcase
                if (byteIdx_ff != `SGCF_NUM_CFG_BYTES) begin
                  byteIdx_ff <= byteIdx_ff + 2'h1;
                end
              end
            end
          end
        end
        `SGCF_ST_ACK: begin
          if (sclFall) begin
            serialDataOe_ff <= 1'b0;
            bitCnt_ff       <= 3'h0;
            state_ff        <= retState_ff;
          end
        end
        `SGCF_ST_IDLE, `SGCF_ST_IGNORE: begin
          serialDataOe_ff <= 1'b0;
        end
        default: begin
          state_ff <= `SGCF_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output gating
  wire [`SGCF_NUM_OUT-1:0] gateReq = {gateHigh_ff[7:`SGCF_HIGH_LSB],
                                      gateMid_ff[7:`SGCF_MID_LSB],
                                      gateLow_ff[3:`SGCF_LOW_LSB]};

  sgcf_out_gate uGate (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .refClk    (refSync_ff[1]),
    .outEnable (oeSync_ff[1]),
    .gateReq   (gateReq),
    .clkOut_ff (fanoutClk),
    .clkOe_ff  (fanoutOe)
  );
endmodule // sgcf_fanout

/* File: bench/sgcf_fanout_sva.sv */
// Checker on the fan-out top ports.
// Assumes ref and link half periods of 8 sys_clk.
`timescale 1ns/1ns
module sgcf_fanout_sva (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       refClkPin,
  input wire logic       outEnablePin,
  input wire logic       serialDataOe_ff,
  input wire logic [9:0] fanoutClk,
  input wire logic [9:0] fanoutOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_rel; $fell(srst) ##0 refClkPin [*8]; endsequence
  sequence s_ack; $rose(serialDataOe_ff); endsequence
  property p_rst; disable iff (1'b0) srst |=> !fanoutOe && !fanoutClk && !serialDataOe_ff;
  endproperty
  a_rst: assert property (p_rst) else $error("reset out");
  property p_power; s_rel |-> fanoutClk == 10'h3FF; endproperty
  a_power: assert property (p_power) else $error("power on");
  property p_oeLow; !outEnablePin [*5] |-> fanoutOe == 10'h000; endproperty
  a_oeLow: assert property (p_oeLow) else $error("oe low");
  property p_oeHigh; outEnablePin [*8] |-> fanoutOe == 10'h3FF; endproperty
  a_oeHigh: assert property (p_oeHigh) else $error("oe high");
  property p_refLow; !refClkPin [*5] |-> fanoutClk == 10'h000; endproperty
  a_refLow: assert property (p_refLow) else $error("ref low");
  property p_pulse; $rose(fanoutClk[9]) |-> fanoutClk[9] [*6]; endproperty
  a_pulse: assert property (p_pulse) else $error("short pulse");
  property p_ackHold; s_ack |-> serialDataOe_ff [*8]; endproperty
  a_ackHold: assert property (p_ackHold) else $error("ack short");
  property p_ackEnd; s_ack |-> ##[9:24] !serialDataOe_ff; endproperty
  a_ackEnd: assert property (p_ackEnd) else $error("ack long");
endmodule // sgcf_fanout_sva

/* File: bench/sgcf_host_model.sv */
// Link host: makes the serial clock, pulls data low.
// Assumes the bench pulls the data wire up.
`timescale 1ns/1ns
module sgcf_host_model (
  input  wire logic sysClk,
  input  wire logic sda,
  output logic      scl = 1'b1,
  output logic      sdaLow = 1'b0
);
  task automatic wt(input int n);
    repeat (n) @(posedge sysClk);
  endtask
  // Data moves while the clock is low, 2 cycles after it falls, so it never looks like a start or stop
  task automatic bitIo(input logic b, output logic r);
    scl <= 1'b0;
    wt(2);
    sdaLow <= ~b;
    wt(6);
    scl <= 1'b1;
    wt(4);
    r = sda;
    wt(4);
  endtask
  task automatic xfer(input logic [47:0] q, output int acks);
    logic r;
    acks = 0;
    wt(1);
    sdaLow <= 1'b1;
    wt(8);
    for (int i = 47; i >= 0; i--) begin
      bitIo(q[i], r);
      if (i % 8 == 0) begin
        bitIo(1'b1, r);
        acks += (r === 1'b0);
      end
    end
    scl <= 1'b0;
    wt(2);
    sdaLow <= 1'b1;
    wt(6);
    scl <= 1'b1;
    wt(8);
    sdaLow <= 1'b0;
    wt(8);
  endtask
endmodule // sgcf_host_model

/* File: bench/sgcf_fanout_tb.sv */
// Bench for the fan-out top.
// Assumes host model and checker compiled first.
`timescale 1ns/1ns
module sgcf_fanout_tb;
  logic       sys_clk = 1'b0;
  logic       srst = 1'b1;
  logic       refClkPin = 1'b1;
  logic       outEnablePin = 1'b1;
  logic       scl, sdaLow, sdaOut, sdaOe;
  logic [9:0] fanoutClk, fanoutOe;
  wire        sda = ~(sdaLow | (sdaOe & ~sdaOut));
  int         error_cnt = 0;
  int         samples_checked = 0;
  sgcf_fanout sgcf_fanout_i (.sys_clk(sys_clk), .srst(srst), .refClkPin(refClkPin),
    .outEnablePin(outEnablePin), .serialClkPin(scl), .serialDataIn(sda),
    .serialDataOut_ff(sdaOut), .serialDataOe_ff(sdaOe), .fanoutClk(fanoutClk),
    .fanoutOe(fanoutOe));
  sgcf_host_model sgcf_host_model_i (.sysClk(sys_clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
  ////////////////////////////////////////
  initial forever #25 sys_clk = ~sys_clk;
  initial begin
    repeat (40) @(posedge sys_clk);
    forever begin
      repeat (8) @(posedge sys_clk);
      refClkPin <= ~refClkPin;
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic refHigh;
    int n = 0;
    while (refClkPin !== 1'b0 && n < 99) @(posedge sys_clk) n++;
    while (refClkPin !== 1'b1 && n < 99) @(posedge sys_clk) n++;
    if (n >= 99) begin
      error_cnt++;
      complete_run();
    end
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_write(input logic [47:0] q, input logic [9:0] expAck, expClk);
    int a;
    sgcf_host_model_i.xfer(q, a);
    chk(10'(a), expAck);
    chk({9'h000, sdaOut}, 10'h000);
    refHigh();
    chk(fanoutClk, expClk);
    $display("write done");
  endtask
  // Reset is released while the reference is low so no short first pulse appears
  task automatic t_rst;
    int n = 0;
    @(posedge sys_clk) srst <= 1'b1;
    while (refClkPin !== 1'b1 && n < 99) @(posedge sys_clk) n++;
    while (refClkPin !== 1'b0 && n < 99) @(posedge sys_clk) n++;
    srst <= 1'b0;
    if (n >= 99) begin
      error_cnt++;
      complete_run();
    end
    refHigh();
    chk(fanoutClk, 10'h3FF);
    $display("mid reset done");
  endtask
  task automatic t_oe;
    @(posedge sys_clk) outEnablePin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 chk(fanoutOe, 10'h000);
    @(posedge sys_clk) outEnablePin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk(fanoutOe, 10'h3FF);
    $display("oe done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk(fanoutClk, 10'h3FF);
    $display("reset done");
    t_write({8'hD2, 8'h00, 8'h03, 8'h05, 8'hA0, 8'h80}, 10'h006, 10'h2A5);
    t_write({8'hD0, 40'h0}, 10'h000, 10'h2A5);
    t_write({8'hD3, 40'h0}, 10'h000, 10'h2A5);
    t_oe();
    t_rst();
    t_write({8'hD2, 8'h00, 8'h03, 8'h05, 8'hA0, 8'h80}, 10'h006, 10'h2A5);
    t_write({8'hD2, 8'h00, 8'h03, 8'h0F, 8'hF0, 8'hC0}, 10'h006, 10'h3FF);
    complete_run();
  end
endmodule // sgcf_fanout_tb
bind sgcf_fanout sgcf_fanout_sva sgcf_fanout_sva_i (.sys_clk(sys_clk), .srst(srst),
  .refClkPin(refClkPin), .outEnablePin(outEnablePin), .serialDataOe_ff(serialDataOe_ff),
  .fanoutClk(fanoutClk), .fanoutOe(fanoutOe));
